// >>> pkg/charger_cfg_params.svh
// Offsets, field positions, reset values and decode constants
`ifndef CHARGER_CFG_PARAMS_SVH
`define CHARGER_CFG_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TERM_TIMER_OFFSET 8'h05
`define BOOST_THERMAL_OFFSET 8'h06

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TERM_TIMER_RESET 8'h9c
`define BOOST_THERMAL_RESET 8'h73

// ----------------------------------------------------------------
// Field positions, termination/timer register
// ----------------------------------------------------------------
`define TERM_EN_BIT 7
`define HOST_TIMEOUT_MSB 5
`define HOST_TIMEOUT_LSB 4
`define SAFETY_TIMER_EN_BIT 3
`define FAST_LIMIT_MSB 2
`define FAST_LIMIT_LSB 1

// ----------------------------------------------------------------
// Field positions, boost/thermal register
// ----------------------------------------------------------------
`define BOOST_V_MSB 7
`define BOOST_V_LSB 4
`define BOOST_HOT_MSB 3
`define BOOST_HOT_LSB 2
`define THERMAL_REG_MSB 1
`define THERMAL_REG_LSB 0

// ----------------------------------------------------------------
// Decoded values
// ----------------------------------------------------------------
`define HOST_TIMEOUT_OFF_S 8'h00
`define HOST_TIMEOUT_40_S 8'h28
`define HOST_TIMEOUT_80_S 8'h50
`define HOST_TIMEOUT_160_S 8'ha0
`define FAST_LIMIT_5_H 5'h05
`define FAST_LIMIT_8_H 5'h08
`define FAST_LIMIT_12_H 5'h0c
`define FAST_LIMIT_20_H 5'h14
`define BOOST_BASE_MV 13'h11c6
`define BOOST_STEP_SHIFT 6
`define BOOST_RESET_MV 13'h1386
`define HOT_PCT_CODE0 6'h21
`define HOT_PCT_CODE1 6'h24
`define HOT_PCT_CODE2 6'h1e
`define HOT_CODE_DISABLE 2'h3
`define THERMAL_60_C 7'h3c
`define THERMAL_80_C 7'h50
`define THERMAL_100_C 7'h64
`define THERMAL_120_C 7'h78

// ----------------------------------------------------------------
// Serial port
// ----------------------------------------------------------------
`define DEVICE_ADDR_DEFAULT 7'h3c
`define BITS_PER_BYTE 4'h8

`endif

// >>> pkg/charger_cfg_pkg.sv
// Types shared by the configuration register block
package charger_cfg_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_wr_byte,
    st_wr_ack,
    st_rd_byte,
    st_rd_ack
  } serial_state_e;

endpackage : charger_cfg_pkg

// >>> rtl/charger_cfg_decode.sv
// Registered decode of configuration fields into physical values
`timescale 1ns/10ps
`default_nettype none
`include "charger_cfg_params.svh"

module charger_cfg_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] term_timer,
  input wire logic [7:0] boost_thermal,
  output logic [7:0] host_timeout_seconds,
  output logic [4:0] fast_charge_limit_hours,
  output logic [12:0] boost_voltage_mv,
  output logic boost_hot_cutoff_enable,
  output logic [5:0] boost_hot_percent,
  output logic [5:0] thermistor_fault_percent,
  output logic [6:0] thermal_regulation_celsius
);

  logic [1:0] hot_code;
  logic [3:0] boost_code;

  assign hot_code = boost_thermal[`BOOST_HOT_MSB:`BOOST_HOT_LSB];
  assign boost_code = boost_thermal[`BOOST_V_MSB:`BOOST_V_LSB];

  // ----------------------------------------------------------------
  // Timer selections
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_timeout_seconds <= `HOST_TIMEOUT_40_S;
      fast_charge_limit_hours <= `FAST_LIMIT_12_H;
    end else if (ce) begin
      unique case (term_timer[`HOST_TIMEOUT_MSB:`HOST_TIMEOUT_LSB])
        2'h0: host_timeout_seconds <= `HOST_TIMEOUT_OFF_S;
        2'h1: host_timeout_seconds <= `HOST_TIMEOUT_40_S;
        2'h2: host_timeout_seconds <= `HOST_TIMEOUT_80_S;
        2'h3: host_timeout_seconds <= `HOST_TIMEOUT_160_S;
      endcase
      unique case (term_timer[`FAST_LIMIT_MSB:`FAST_LIMIT_LSB])
        2'h0: fast_charge_limit_hours <= `FAST_LIMIT_5_H;
        2'h1: fast_charge_limit_hours <= `FAST_LIMIT_8_H;
        2'h2: fast_charge_limit_hours <= `FAST_LIMIT_12_H;
        2'h3: fast_charge_limit_hours <= `FAST_LIMIT_20_H;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Boost voltage and thermal thresholds
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_voltage_mv <= `BOOST_RESET_MV;
      boost_hot_cutoff_enable <= 1'b1;
      boost_hot_percent <= `HOT_PCT_CODE0;
      thermistor_fault_percent <= `HOT_PCT_CODE0;
      thermal_regulation_celsius <= `THERMAL_120_C;
    end else if (ce) begin
      // Binary weights 512/256/128/64 mV are the code times 64
      boost_voltage_mv <= `BOOST_BASE_MV +
        {3'h0, boost_code, 6'h00};
      boost_hot_cutoff_enable <= (hot_code != `HOT_CODE_DISABLE);
      unique case (hot_code)
        2'h0: begin
          boost_hot_percent <= `HOT_PCT_CODE0;
          thermistor_fault_percent <= `HOT_PCT_CODE0;
        end
        2'h1: begin
          boost_hot_percent <= `HOT_PCT_CODE1;
          thermistor_fault_percent <= `HOT_PCT_CODE1;
        end
        2'h2: begin
          boost_hot_percent <= `HOT_PCT_CODE2;
          thermistor_fault_percent <= `HOT_PCT_CODE2;
        end
        2'h3: begin
          // Cut-off off, but the fault still watches the default level
          boost_hot_percent <= `HOT_PCT_CODE0;
          thermistor_fault_percent <= `HOT_PCT_CODE0;
        end
      endcase
      unique case (boost_thermal[`THERMAL_REG_MSB:`THERMAL_REG_LSB])
        2'h0: thermal_regulation_celsius <= `THERMAL_60_C;
        2'h1: thermal_regulation_celsius <= `THERMAL_80_C;
        2'h2: thermal_regulation_celsius <= `THERMAL_100_C;
        2'h3: thermal_regulation_celsius <= `THERMAL_120_C;
      endcase
    end
  end

endmodule : charger_cfg_decode
`default_nettype wire

// >>> rtl/charger_timer_boost_config_regs.sv
// Termination/timer and boost/thermal registers behind a serial slave
`timescale 1ns/10ps
`default_nettype none
`include "charger_cfg_params.svh"

module charger_timer_boost_config_regs #(
  // Arbitrary neutral bus address
  parameter logic [6:0] DEVICE_ADDR = `DEVICE_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic termination_enable,
  output logic [1:0] host_timeout_select,
  output logic safety_timer_enable,
  output logic [1:0] fast_charge_limit_select,
  output logic [3:0] boost_voltage_code,
  output logic [1:0] boost_hot_select,
  output logic [1:0] thermal_regulation_threshold,
  output logic [7:0] host_timeout_seconds,
  output logic [4:0] fast_charge_limit_hours,
  output logic [12:0] boost_voltage_mv,
  output logic boost_hot_cutoff_enable,
  output logic [5:0] boost_hot_percent,
  output logic [5:0] thermistor_fault_percent,
  output logic [6:0] thermal_regulation_celsius
);

  charger_cfg_pkg::serial_state_e state;
  logic scl_q;
  logic sda_q;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] rd_shift;
  logic read_mode;
  logic pointer_next;
  logic master_nack;
  logic [7:0] pointer;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] term_timer;
  logic [7:0] boost_thermal;
  logic [7:0] rd_data;

  // ----------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------
  // Pins are synchronous to clk, so one sample stage suffices for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped pointers read as zero and ignore writes
  always_comb begin
    rd_data = 8'h00;
    if (pointer == `TERM_TIMER_OFFSET) begin
      rd_data = term_timer;
    end else if (pointer == `BOOST_THERMAL_OFFSET) begin
      rd_data = boost_thermal;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= charger_cfg_pkg::st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rd_shift <= 8'h00;
      read_mode <= 1'b0;
      pointer_next <= 1'b0;
      master_nack <= 1'b0;
      pointer <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      if (start_seen) begin
        // Repeated start keeps the pointer for a following read
        state <= charger_cfg_pkg::st_addr;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= charger_cfg_pkg::st_idle;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          charger_cfg_pkg::st_addr,
          charger_cfg_pkg::st_wr_byte: begin
            shift <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end
          charger_cfg_pkg::st_rd_byte: begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          charger_cfg_pkg::st_rd_ack: begin
            master_nack <= sda_in;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state)
          charger_cfg_pkg::st_idle: begin
            sda_oe <= 1'b0;
          end
          charger_cfg_pkg::st_addr: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              if (shift[7:1] == DEVICE_ADDR) begin
                sda_oe <= 1'b1;
                read_mode <= shift[0];
                state <= charger_cfg_pkg::st_addr_ack;
              end else begin
                state <= charger_cfg_pkg::st_idle;
              end
            end
          end
          charger_cfg_pkg::st_addr_ack: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              sda_oe <= ~rd_data[7];
              rd_shift <= {rd_data[6:0], 1'b0};
              state <= charger_cfg_pkg::st_rd_byte;
            end else begin
              sda_oe <= 1'b0;
              pointer_next <= 1'b1;
              state <= charger_cfg_pkg::st_wr_byte;
            end
          end
          charger_cfg_pkg::st_wr_byte: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              sda_oe <= 1'b1;
              state <= charger_cfg_pkg::st_wr_ack;
              if (pointer_next) begin
                pointer <= shift;
                pointer_next <= 1'b0;
              end else begin
                wr_stb <= 1'b1;
                wr_addr <= pointer;
                wr_data <= shift;
                pointer <= pointer + 8'h01;
              end
            end
          end
          charger_cfg_pkg::st_wr_ack: begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            state <= charger_cfg_pkg::st_wr_byte;
          end
          charger_cfg_pkg::st_rd_byte: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              pointer <= pointer + 8'h01;
              state <= charger_cfg_pkg::st_rd_ack;
            end else begin
              sda_oe <= ~rd_shift[7];
              rd_shift <= {rd_shift[6:0], 1'b0};
            end
          end
          charger_cfg_pkg::st_rd_ack: begin
            bit_cnt <= 4'h0;
            if (master_nack) begin
              sda_oe <= 1'b0;
              state <= charger_cfg_pkg::st_idle;
            end else begin
              sda_oe <= ~rd_data[7];
              rd_shift <= {rd_data[6:0], 1'b0};
              state <= charger_cfg_pkg::st_rd_byte;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // All eight bits are kept, so reserved bits read back what was written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_timer <= `TERM_TIMER_RESET;
    end else if (ce && wr_stb && wr_addr == `TERM_TIMER_OFFSET) begin
      term_timer <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_thermal <= `BOOST_THERMAL_RESET;
    end else if (ce && wr_stb && wr_addr == `BOOST_THERMAL_OFFSET) begin
      boost_thermal <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Raw field outputs
  // ----------------------------------------------------------------
  assign termination_enable = term_timer[`TERM_EN_BIT];
  assign host_timeout_select =
    term_timer[`HOST_TIMEOUT_MSB:`HOST_TIMEOUT_LSB];
  assign safety_timer_enable = term_timer[`SAFETY_TIMER_EN_BIT];
  assign fast_charge_limit_select =
    term_timer[`FAST_LIMIT_MSB:`FAST_LIMIT_LSB];
  assign boost_voltage_code =
    boost_thermal[`BOOST_V_MSB:`BOOST_V_LSB];
  assign boost_hot_select =
    boost_thermal[`BOOST_HOT_MSB:`BOOST_HOT_LSB];
  assign thermal_regulation_threshold =
    boost_thermal[`THERMAL_REG_MSB:`THERMAL_REG_LSB];

  // ----------------------------------------------------------------
  // Physical-value decode
  // ----------------------------------------------------------------
  charger_cfg_decode u_decode (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .term_timer(term_timer),
    .boost_thermal(boost_thermal),
    .host_timeout_seconds(host_timeout_seconds),
    .fast_charge_limit_hours(fast_charge_limit_hours),
    .boost_voltage_mv(boost_voltage_mv),
    .boost_hot_cutoff_enable(boost_hot_cutoff_enable),
    .boost_hot_percent(boost_hot_percent),
    .thermistor_fault_percent(thermistor_fault_percent),
    .thermal_regulation_celsius(thermal_regulation_celsius)
  );

endmodule : charger_timer_boost_config_regs
`default_nettype wire

// >>> tb/charger_cfg_assertions.sv
// Port-level checker for the configuration register block
`timescale 1ns/10ps
`default_nettype none
module charger_cfg_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic termination_enable,
  input wire logic [1:0] host_timeout_select,
  input wire logic safety_timer_enable,
  input wire logic [1:0] fast_charge_limit_select,
  input wire logic [3:0] boost_voltage_code,
  input wire logic [1:0] boost_hot_select,
  input wire logic [1:0] thermal_regulation_threshold,
  input wire logic [7:0] host_timeout_seconds,
  input wire logic [4:0] fast_charge_limit_hours,
  input wire logic [12:0] boost_voltage_mv,
  input wire logic boost_hot_cutoff_enable,
  input wire logic [5:0] boost_hot_percent,
  input wire logic [5:0] thermistor_fault_percent,
  input wire logic [6:0] thermal_regulation_celsius
);
  // ----------------------------------------------------------------
  // Decode tables and properties
  // ----------------------------------------------------------------
  localparam logic [7:0] TO_S [4] = '{8'h00, 8'h28, 8'h50, 8'ha0};
  localparam logic [4:0] HRS [4] = '{5'h05, 5'h08, 5'h0c, 5'h14};
  localparam logic [5:0] PCT [4] = '{6'h21, 6'h24, 6'h1e, 6'h21};
  localparam logic [6:0] DEG [4] = '{7'h3c, 7'h50, 7'h64, 7'h78};
  logic [13:0] cfg;
  assign cfg = {termination_enable, host_timeout_select, safety_timer_enable,
    fast_charge_limit_select, boost_voltage_code, boost_hot_select,
    thermal_regulation_threshold};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cfg_change;
    !$stable(cfg);
  endsequence
  // Registers only move on a completed byte, inside an SCL low phase
  property p_cfg_on_write;
    s_cfg_change |-> !scl_in && !$past(scl_in);
  endproperty
  a_cfg_on_write: assert property (p_cfg_on_write)
    else $error("configuration changed outside a write slot");
  property p_reset_values;
    $rose(rst_n) |-> cfg == {6'h2e, 8'h73};
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong configuration after reset");
  property p_sda_low_only;
    sda_out == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only)
    else $error("data line driven high");
  // Device may only move SDA while SCL is low, or it fakes START/STOP
  property p_sda_moves_low;
    !$stable(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_sda_moves_low: assert property (p_sda_moves_low)
    else $error("data line moved while clock high");
  property p_timeout_decode;
    ce |=> host_timeout_seconds == TO_S[$past(host_timeout_select)];
  endproperty
  a_timeout_decode: assert property (p_timeout_decode)
    else $error("timeout seconds wrong");
  property p_limit_decode;
    ce |=> fast_charge_limit_hours == HRS[$past(fast_charge_limit_select)];
  endproperty
  a_limit_decode: assert property (p_limit_decode)
    else $error("fast charge hours wrong");
  property p_boost_mv;
    ce |=> boost_voltage_mv ==
      13'h11c6 + {3'h0, $past(boost_voltage_code), 6'h00};
  endproperty
  a_boost_mv: assert property (p_boost_mv)
    else $error("boost millivolts wrong");
  property p_hot_decode;
    ce |=> boost_hot_cutoff_enable == ($past(boost_hot_select) != 2'h3) &&
      boost_hot_percent == PCT[$past(boost_hot_select)] &&
      thermistor_fault_percent == PCT[$past(boost_hot_select)];
  endproperty
  a_hot_decode: assert property (p_hot_decode)
    else $error("hot threshold decode wrong");
  property p_thermal_decode;
    ce |=> thermal_regulation_celsius ==
      DEG[$past(thermal_regulation_threshold)];
  endproperty
  a_thermal_decode: assert property (p_thermal_decode)
    else $error("thermal regulation decode wrong");
  // Clock enable low must hold the configuration fields, boost millivolts and the data line driver
  property p_ce_freeze;
    !ce |=> $stable(cfg) && $stable(sda_oe) && $stable(boost_voltage_mv);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while clock enable low");
endmodule : charger_cfg_assertions

bind charger_timer_boost_config_regs charger_cfg_assertions
  charger_cfg_assertions_inst (.clk, .rst_n, .ce, .scl_in, .sda_out, .sda_oe,
  .termination_enable, .host_timeout_select, .safety_timer_enable,
  .fast_charge_limit_select, .boost_voltage_code, .boost_hot_select,
  .thermal_regulation_threshold, .host_timeout_seconds,
  .fast_charge_limit_hours, .boost_voltage_mv, .boost_hot_cutoff_enable,
  .boost_hot_percent, .thermistor_fault_percent,
  .thermal_regulation_celsius);
`default_nettype wire

// >>> tb/i2c_host_model.sv
// Serial bus host model: open-drain master driving SCL and SDA
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // ----------------------------------------------------------------
  // Bit and byte tasks
  // ----------------------------------------------------------------
  // Four clocks per SCL phase keeps above the three-clock minimum
  localparam int HALF = 4;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start_cond();
    sda = 1'b1;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    sda = 1'b0;
    repeat (HALF) @(negedge clk);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    sda = 1'b0;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    sda = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask : stop_cond
  // Data is sampled just before SCL falls, when the line has settled
  task automatic put_bit(input logic b, output logic got);
    sda = b;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    got = sda_line;
    scl = 1'b0;
  endtask : put_bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(d[i], g);
    put_bit(1'b1, g);
    ack = ~g;
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      d[i] = g;
    end
    put_bit(last, g);
  endtask : recv_byte
endmodule : i2c_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the configuration register block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h2a; // Arbitrary bus address
  localparam logic [7:0] TO_S [4] = '{8'h00, 8'h28, 8'h50, 8'ha0};
  localparam logic [4:0] HRS [4] = '{5'h05, 5'h08, 5'h0c, 5'h14};
  localparam logic [5:0] PCT [4] = '{6'h21, 6'h24, 6'h1e, 6'h21};
  localparam logic [6:0] DEG [4] = '{7'h3c, 7'h50, 7'h64, 7'h78};
  logic clk, rst_n, ce, scl, sda_m, sda_line, sda_out, sda_oe;
  logic term_en, safety_en, cutoff;
  logic [1:0] to_sel, fast_sel, hot_sel, thermal_regulation_threshold_sel;
  logic [3:0] bv_code;
  logic [7:0] to_s, t, b;
  logic [4:0] hours;
  logic [12:0] mv;
  logic [5:0] hot_pct, fault_pct;
  logic [6:0] deg_c;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  // Open drain: either party pulling low wins
  assign sda_line = sda_m & ~sda_oe;
  charger_timer_boost_config_regs #(.DEVICE_ADDR(DEV_ADDR))
    charger_timer_boost_config_regs_inst (.clk(clk), .rst_n(rst_n),
    .ce(ce), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .termination_enable(term_en),
    .host_timeout_select(to_sel), .safety_timer_enable(safety_en),
    .fast_charge_limit_select(fast_sel), .boost_voltage_code(bv_code),
    .boost_hot_select(hot_sel), .thermal_regulation_threshold(thermal_regulation_threshold_sel),
    .host_timeout_seconds(to_s), .fast_charge_limit_hours(hours),
    .boost_voltage_mv(mv), .boost_hot_cutoff_enable(cutoff),
    .boost_hot_percent(hot_pct), .thermistor_fault_percent(fault_pct),
    .thermal_regulation_celsius(deg_c));
  i2c_host_model i2c_host_model_inst (.clk(clk), .sda_line(sda_line),
    .scl(scl), .sda(sda_m));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic xfer(input logic [7:0] d, input logic exp_ack);
    logic ack;
    i2c_host_model_inst.send_byte(d, ack);
    cmp({15'h0, ack}, {15'h0, exp_ack});
  endtask : xfer
  task automatic write_regs(input logic [7:0] p, d0, d1);
    i2c_host_model_inst.start_cond();
    xfer({DEV_ADDR, 1'b0}, 1'b1);
    xfer(p, 1'b1);
    xfer(d0, 1'b1);
    xfer(d1, 1'b1);
    i2c_host_model_inst.stop_cond();
  endtask : write_regs
  task automatic read_regs(input logic [7:0] p, e0, e1);
    logic [7:0] g;
    i2c_host_model_inst.start_cond();
    xfer({DEV_ADDR, 1'b0}, 1'b1);
    xfer(p, 1'b1);
    i2c_host_model_inst.start_cond();
    xfer({DEV_ADDR, 1'b1}, 1'b1);
    i2c_host_model_inst.recv_byte(1'b0, g);
    cmp({8'h00, g}, {8'h00, e0});
    i2c_host_model_inst.recv_byte(1'b1, g);
    cmp({8'h00, g}, {8'h00, e1});
    i2c_host_model_inst.stop_cond();
  endtask : read_regs
  task automatic check_state(input logic [7:0] et, eb);
    cmp({2'h0, term_en, to_sel, safety_en, fast_sel, bv_code, hot_sel,
      thermal_regulation_threshold_sel}, {2'h0, et[7], et[5:1], eb});
    cmp({8'h00, to_s}, {8'h00, TO_S[et[5:4]]});
    cmp({11'h0, hours}, {11'h0, HRS[et[2:1]]});
    cmp({3'h0, mv}, {3'h0, 13'h11c6 + {3'h0, eb[7:4], 6'h00}});
    cmp({3'h0, cutoff, hot_pct, fault_pct},
      {3'h0, eb[3:2] != 2'h3, PCT[eb[3:2]], PCT[eb[3:2]]});
    cmp({9'h0, deg_c}, {9'h0, DEG[eb[1:0]]});
  endtask : check_state
  // ----------------------------------------------------------------
  // Timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check_state(8'h9c, 8'h73);
    read_regs(8'h05, 8'h9c, 8'h73);
    // Every two-bit field code once, boost codes 0/5/10/15 only, reserved bits toggled
    for (int i = 0; i < 4; i++) begin
      t = {i[0], ~i[0], i[1:0], i[1], i[1:0], i[0]};
      b = {4'(i * 5), i[1:0], 2'(3 - i)};
      write_regs(8'h05, t, b);
      read_regs(8'h05, t, b);
      check_state(t, b);
    end
    // Unmapped offsets read zero and leave the registers alone
    write_regs(8'h07, 8'h55, 8'haa);
    read_regs(8'h07, 8'h00, 8'h00);
    check_state(t, b);
    // Clock enable low: the whole write is missed, nothing acknowledged
    ce = 1'b0;
    i2c_host_model_inst.start_cond();
    xfer({DEV_ADDR, 1'b0}, 1'b0);
    xfer(8'h05, 1'b0);
    xfer(8'h00, 1'b0);
    i2c_host_model_inst.stop_cond();
    ce = 1'b1;
    check_state(t, b);
    // Foreign address must not be acknowledged
    i2c_host_model_inst.start_cond();
    xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
    i2c_host_model_inst.stop_cond();
    // Reset in mid-run restores defaults
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check_state(8'h9c, 8'h73);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
